// ===== filament_bridge.sv
// Purpose: filament full-bridge waveform, phase pin selectors, map port
// Assumes: register commands arrive as single-cycle strobes on clk
// Notes:   shutdown and blink phase come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module filament_bridge (
	input  wire logic                    clk,          // 40 MHz clock
	input  wire logic                    srst,         // sync reset, high
	input  wire filament_pkg::reg_req_t  req,          // command strobe
	input  wire logic                    shutdown,     // device shut down
	input  wire logic                    blink_phase,  // 0 first, 1 second
	output logic [7:0]                   rdata,        // read answer
	output logic                         rvalid,       // read answer pulse
	output logic [6:0]                   map_pointer,  // current pointer
	output logic                         filament_drive_a, // phase a pin
	output logic                         filament_drive_b  // phase b pin
);
	import filament_pkg::*;

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	wire hit_port  = (req.addr == CMD_MAP_PORT);
	wire hit_on    = (req.addr == CMD_ON_TIME);
	wire hit_sel_a = (req.addr == CMD_SEL_A);
	wire hit_sel_b = (req.addr == CMD_SEL_B);

	wire port_wr   = req.wr && hit_port;
	wire ptr_load  = port_wr && req.wdata[PORT_CMD_BIT];
	wire map_store = port_wr && !req.wdata[PORT_CMD_BIT];
	// a write wins over a read issued in the same cycle
	wire map_read  = req.rd && !req.wr && hit_port;

	// ------------------------------------------------------------
	// output map pointer and storage
	// ------------------------------------------------------------
	logic [6:0] ptr_reg;
	logic [6:0] ptr_next;
	logic [6:0] ptr_inc;
	logic [6:0] map_entry;

	// past the last location the pointer wraps to the first
	assign ptr_inc = (ptr_reg >= PTR_MAX) ? PTR_RESET : ptr_reg + 7'h01;

	assign ptr_next = ptr_load ? req.wdata[6:0] :
	                  (map_store || map_read) ? ptr_inc :
	                  ptr_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			ptr_reg <= PTR_RESET;
		end else begin
			ptr_reg <= ptr_next;
		end
	end

	output_map_ram u_map (
		.clk   (clk),
		.wr_en (map_store),
		.addr  (ptr_reg),
		.wdata (req.wdata[6:0]),
		.rdata (map_entry)
	);

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	logic [7:0] on_time_reg;
	logic [7:0] on_time_next;
	out_sel_t   sel_a_reg;
	out_sel_t   sel_a_next;
	out_sel_t   sel_b_reg;
	out_sel_t   sel_b_next;

	assign on_time_next = (req.wr && hit_on) ? req.wdata : on_time_reg;
	// only the two low bits are kept
	assign sel_a_next = (req.wr && hit_sel_a) ?
	                    out_sel_t'(req.wdata[SEL_W-1:0]) : sel_a_reg;
	assign sel_b_next = (req.wr && hit_sel_b) ?
	                    out_sel_t'(req.wdata[SEL_W-1:0]) : sel_b_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			on_time_reg <= ON_TIME_RESET;
			sel_a_reg   <= SEL_RESET;
			sel_b_reg   <= SEL_RESET;
		end else begin
			on_time_reg <= on_time_next;
			sel_a_reg   <= sel_a_next;
			sel_b_reg   <= sel_b_next;
		end
	end

	// ------------------------------------------------------------
	// read answer
	// ------------------------------------------------------------
	logic [7:0] rsel;

	assign rsel = hit_port  ? {1'b0, map_entry} :
	              hit_on    ? on_time_reg :
	              hit_sel_a ? {6'h00, sel_a_reg} :
	              hit_sel_b ? {6'h00, sel_b_reg} :
	              8'h00;

	logic [7:0] rdata_reg;
	logic       rvalid_reg;
	wire        rd_take = req.rd && !req.wr;

	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_reg  <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg  <= rd_take ? rsel : rdata_reg;
			rvalid_reg <= rd_take;
		end
	end

	assign rdata       = rdata_reg;
	assign rvalid      = rvalid_reg;
	assign map_pointer = ptr_reg;

	// ------------------------------------------------------------
	// oscillator tick
	// ------------------------------------------------------------
	logic [3:0] div_reg;
	wire        osc_tick = (div_reg == DIV_LAST);

	always_ff @(posedge clk) begin
		if (srst) begin
			div_reg <= 4'h0;
		end else begin
			div_reg <= osc_tick ? 4'h0 : div_reg + 4'h1;
		end
	end

	// ------------------------------------------------------------
	// frame position and latched on-time
	// ------------------------------------------------------------
	logic [8:0] pos_reg;
	logic [8:0] pos_next;
	logic [7:0] frame_on_reg;
	wire        frame_end = osc_tick && (pos_reg == FRAME_LAST);

	// shutdown parks the frame at its start so it restarts cleanly
	assign pos_next = shutdown ? 9'h000 :
	                  frame_end ? 9'h000 :
	                  osc_tick ? pos_reg + 9'h001 : pos_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			pos_reg      <= 9'h000;
			frame_on_reg <= ON_TIME_RESET;
		end else begin
			pos_reg      <= pos_next;
			// taken between frames or while shut down so no period is cut short
			if (frame_end || shutdown) begin
				frame_on_reg <= on_time_reg;
			end
		end
	end

	// ------------------------------------------------------------
	// bridge waveform
	// ------------------------------------------------------------
	logic [8:0] lead_end;
	logic [8:0] a_end;
	logic       wave_b;
	logic       wave_a;

	// lead idle is 0 .. 198-on, closing idle starts at 201+on
	assign lead_end = B_END - {1'b0, frame_on_reg};
	assign a_end    = A_START + {1'b0, frame_on_reg};
	assign wave_b   = (pos_reg >= lead_end) && (pos_reg < B_END);
	assign wave_a   = (pos_reg >= A_START) && (pos_reg < a_end);

	drive_pair_t fil;
	assign fil.a = wave_a && !shutdown;
	assign fil.b = wave_b && !shutdown;

	// ------------------------------------------------------------
	// pin selectors
	// ------------------------------------------------------------
	logic pin_a_next;
	logic pin_b_next;

	always_comb begin
		case (sel_a_reg)
			SEL_LOW:      pin_a_next = 1'b0;
			SEL_HIGH:     pin_a_next = 1'b1;
			SEL_BLINK:    pin_a_next = blink_phase;
			SEL_FILAMENT: pin_a_next = fil.a;
			default:      pin_a_next = 1'b0;
		endcase
	end

	always_comb begin
		case (sel_b_reg)
			SEL_LOW:      pin_b_next = 1'b0;
			SEL_HIGH:     pin_b_next = 1'b1;
			SEL_BLINK:    pin_b_next = blink_phase;
			SEL_FILAMENT: pin_b_next = fil.b;
			default:      pin_b_next = 1'b0;
		endcase
	end

	logic drive_a_reg;
	logic drive_b_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			drive_a_reg <= 1'b0;
			drive_b_reg <= 1'b0;
		end else begin
			drive_a_reg <= pin_a_next;
			drive_b_reg <= pin_b_next;
		end
	end

	assign filament_drive_a = drive_a_reg;
	assign filament_drive_b = drive_b_reg;

endmodule

`default_nettype wire

// ===== filament_bridge_sva.sv
// Purpose: port assertions for filament_bridge
// Assumes: one clock, srst synchronous active high
// Notes:   bridge timing is judged by the bench; selector codes here
`timescale 1ns/1ps
`default_nettype none
module filament_bridge_sva (
	input wire logic                   clk,              // clock
	input wire logic                   srst,             // reset
	input wire filament_pkg::reg_req_t req,              // command
	input wire logic                   shutdown,         // shut down
	input wire logic                   blink_phase,      // blink phase
	input wire logic [7:0]             rdata,            // read data
	input wire logic                   rvalid,           // read pulse
	input wire logic [6:0]             map_pointer,      // pointer
	input wire logic                   filament_drive_a, // pin a
	input wire logic                   filament_drive_b  // pin b
);
	import filament_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	wire hit = req.addr == CMD_MAP_PORT;
	wire bump = hit && (req.wr ? !req.wdata[PORT_CMD_BIT] : req.rd);
	// selector codes as last written; pins follow them one clock later
	logic [1:0] sel_a_seen;
	logic [1:0] sel_b_seen;
	always_ff @(posedge clk) begin
		if (srst) begin
			sel_a_seen <= 2'h0;
			sel_b_seen <= 2'h0;
		end else begin
			if (req.wr && req.addr == CMD_SEL_A) begin
				sel_a_seen <= req.wdata[1:0];
			end
			if (req.wr && req.addr == CMD_SEL_B) begin
				sel_b_seen <= req.wdata[1:0];
			end
		end
	end
	// --------
	// assertions
	// --------
	a_read_answer: assert property (req.rd && !req.wr |=> rvalid)
		else $error("read not answered");
	a_no_spurious: assert property (!req.rd || req.wr |=> !rvalid)
		else $error("answer without read");
	a_read_top: assert property (rvalid && $past(hit) |-> !rdata[7])
		else $error("map read top bit set");
	a_ptr_load: assert property (req.wr && hit && req.wdata[7] |=>
		map_pointer == $past(req.wdata[6:0]))
		else $error("pointer not loaded");
	a_ptr_step: assert property (bump |=> map_pointer ==
		($past(map_pointer) == PTR_MAX ? PTR_RESET : $past(map_pointer) + 7'h01))
		else $error("pointer did not advance");
	a_ptr_hold: assert property (!(hit && (req.wr || req.rd)) |=>
		$stable(map_pointer))
		else $error("pointer moved on its own");
	a_ptr_reset: assert property ($past(srst) |-> map_pointer == PTR_RESET)
		else $error("pointer not zero after reset");
	a_rdata_hold: assert property (!rvalid && !$past(srst) |-> $stable(rdata))
		else $error("read data changed without answer");
	a_pin_low: assert property ($past(sel_a_seen) == 2'h0 |->
		!filament_drive_a)
		else $error("pin a not static low");
	a_pin_blink: assert property ($past(sel_a_seen) == 2'h2 |->
		filament_drive_a == $past(blink_phase))
		else $error("pin a not following blink phase");
	a_shut_low: assert property ($past(shutdown) &&
		$past(sel_a_seen) == 2'h3 |-> !filament_drive_a)
		else $error("pin a driven in shutdown");
	a_bridge_split: assert property ($past(sel_a_seen) == 2'h3 &&
		$past(sel_b_seen) == 2'h3 |->
		!(filament_drive_a && filament_drive_b))
		else $error("both bridge phases high");
	c_read: cover property (rvalid);
	c_wrap: cover property ($past(map_pointer) == PTR_MAX && map_pointer == PTR_RESET);
	c_phase_b: cover property ($rose(filament_drive_b));
endmodule
bind filament_bridge filament_bridge_sva i_sva (.clk, .srst, .req,
	.shutdown, .blink_phase, .rdata, .rvalid, .map_pointer,
	.filament_drive_a, .filament_drive_b);
`default_nettype wire

// ===== filament_load.sv
// Purpose: filament bridge load, measures each drive pulse
// Assumes: pins sampled on the system clock
// Notes:   idle count saturates so a long idle reads as 0xFFF
`timescale 1ns/1ps
`default_nettype none
module filament_load (
	input  wire logic        clk,   // clock
	input  wire logic        drv_a, // phase a pin
	input  wire logic        drv_b, // phase b pin
	output logic             done,  // a pulse just ended
	output logic [11:0]      len,   // clocks it was high
	output logic [11:0]      gap    // clocks low before it
);
	logic [11:0] hi = '0;
	logic [11:0] lo = '0;
	logic [11:0] gcap = '0;
	logic        was = 1'b0;
	always @(posedge clk) begin
		done <= 1'b0;
		was <= drv_a | drv_b;
		if (drv_a | drv_b) begin
			hi <= hi + 12'h001;
			lo <= '0;
			if (!was) gcap <= lo;
		end else begin
			hi <= '0;
			lo <= (lo == 12'hFFF) ? lo : lo + 12'h001;
			if (was) begin
				done <= 1'b1;
				len <= hi;
				gap <= gcap;
			end
		end
	end
endmodule
`default_nettype wire

// ===== filament_pkg.sv
// Purpose: shared constants and types for the filament bridge block
// Assumes: 40 MHz system clock, 4 MHz oscillator tick derived from it
// Notes:   command addresses are the device's register command codes
package filament_pkg;

	// ------------------------------------------------------------
	// command addresses
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_MAP_PORT = 8'h06;
	localparam logic [7:0] CMD_ON_TIME  = 8'h09;
	localparam logic [7:0] CMD_SEL_A    = 8'h0A;
	localparam logic [7:0] CMD_SEL_B    = 8'h0B;

	// ------------------------------------------------------------
	// output map port fields and reset values
	// ------------------------------------------------------------
	localparam int         PORT_CMD_BIT  = 7;
	localparam int         MAP_AW        = 7;
	localparam int         MAP_DW        = 7;
	localparam logic [6:0] PTR_RESET     = 7'h00;
	localparam logic [6:0] PTR_MAX       = 7'h79;
	localparam int         MAP_DEPTH     = 122;
	localparam logic [7:0] ON_TIME_RESET = 8'h01;
	localparam logic [7:0] ON_TIME_MIN   = 8'h01;
	localparam logic [7:0] ON_TIME_MAX   = 8'hC7;
	localparam int         SEL_W         = 2;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ       = 40_000_000;
	localparam int OSC_HZ       = 4_000_000;
	localparam int OSC_DIV      = CLK_HZ / OSC_HZ;
	localparam int FRAME_US     = 100;
	localparam int FRAME_CYCLES = FRAME_US * (OSC_HZ / 1_000_000);
	localparam int IDLE_BASE    = 199;
	localparam int GAP_CYCLES   = 2;
	localparam logic [3:0] DIV_LAST   = 4'(OSC_DIV - 1);
	localparam logic [8:0] FRAME_LAST = 9'(FRAME_CYCLES - 1);
	localparam logic [8:0] B_END      = 9'(IDLE_BASE);
	localparam logic [8:0] A_START    = 9'(IDLE_BASE + GAP_CYCLES);

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SEL_LOW,
		SEL_HIGH,
		SEL_BLINK,
		SEL_FILAMENT
	} out_sel_t;

	localparam out_sel_t SEL_RESET = SEL_LOW;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic a;
		logic b;
	} drive_pair_t;

endpackage

// ===== output_map_ram.sv
// Purpose: output map storage, one 7-bit entry per location
// Assumes: single clock, write and read addressed by the same pointer
// Notes:   locations past the map depth ignore writes and read as zero
`timescale 1ns/1ps
`default_nettype none

module output_map_ram (
	input  wire logic                              clk,   // system clock
	input  wire logic                              wr_en, // store strobe
	input  wire logic [filament_pkg::MAP_AW-1:0]   addr,  // entry index
	input  wire logic [filament_pkg::MAP_DW-1:0]   wdata, // entry to store
	output logic      [filament_pkg::MAP_DW-1:0]   rdata  // entry at addr
);
	import filament_pkg::*;

	logic [MAP_DW-1:0] mem [MAP_DEPTH];
	wire               in_range = (32'(addr) < MAP_DEPTH);

	always_ff @(posedge clk) begin
		if (wr_en && in_range) begin
			mem[addr] <= wdata;
		end
	end

	assign rdata = in_range ? mem[addr] : '0;

endmodule

`default_nettype wire

// ===== test_filament_bridge.sv
// Purpose: self-checking bench for filament_bridge
// Assumes: 40 MHz clock, load model on both pins
// Notes:   pulses are only scored once the filament test arms them
`timescale 1ns/1ps
`default_nettype none
module test_filament_bridge;
	import filament_pkg::*;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	reg_req_t    req = '0;
	logic        shutdown = 1'b0;
	logic        blink_phase = 1'b0;
	logic [7:0]  rdata;
	logic        rvalid;
	logic [6:0]  map_pointer;
	logic        drv_a, drv_b, done, pulse_on = 1'b0, exp;
	logic [11:0] len, gap;
	logic [7:0]  t1, t2;
	logic [6:0]  d[3];
	logic [1:0]  code;
	logic [23:0] rq[$];
	logic [23:0] pq[$];
	int          errors = 0;
	int          checked = 0;
	always #12.5 clk = ~clk;
	filament_bridge i_dut (.clk, .srst, .req, .shutdown, .blink_phase,
		.rdata, .rvalid, .map_pointer, .filament_drive_a(drv_a),
		.filament_drive_b(drv_b));
	filament_load i_load (.clk, .drv_a, .drv_b, .done, .len, .gap);
	// --------
	// tasks
	// --------
	task automatic chk(input logic [23:0] e, input logic [23:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic chk_read(input logic [7:0] g);
		if (rq.size() == 0) chk(24'hFFFFFF, {16'h0000, g});
		else chk(rq.pop_front(), {16'h0000, g});
	endtask
	task automatic chk_pulse(input logic [11:0] g_gap, input logic [11:0] g_len);
		if (pq.size() == 0) chk(24'hFFFFFF, {g_gap, g_len});
		else chk(pq.pop_front(), {g_gap, g_len});
	endtask
	task automatic chk_ptr(input logic [6:0] e);
		chk({17'h0, e}, {17'h0, map_pointer});
	endtask
	task automatic chk_pins(input logic ea, input logic eb);
		chk({22'h0, ea, eb}, {22'h0, drv_a, drv_b});
	endtask
	task automatic op(input logic [7:0] a, input logic w, input logic [7:0] v);
		@(posedge clk);
		req <= '{addr: a, wr: w, rd: !w, wdata: v};
	endtask
	task automatic idle(input int n);
		@(posedge clk);
		req <= '0;
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic wrap_up();
		$display("checked=%0d errors=%0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		if (rvalid === 1'b1) chk_read(rdata);
		if (done === 1'b1 && pulse_on) chk_pulse(gap, len);
	end
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		wrap_up();
	end
	initial begin
		void'($urandom(32'h7A7F));
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		chk_ptr(7'h00);
		chk_pins(1'b0, 1'b0);
		op(CMD_MAP_PORT, 1'b1, 8'hF8);
		foreach (d[i]) begin
			d[i] = 7'($urandom);
			op(CMD_MAP_PORT, 1'b1, {1'b0, d[i]});
		end
		op(8'h0C, 1'b1, 8'h55);
		idle(1);
		chk_ptr(7'h01);
		op(CMD_MAP_PORT, 1'b1, 8'hF8);
		foreach (d[i]) begin
			rq.push_back({17'h0, d[i]});
			op(CMD_MAP_PORT, 1'b0, 8'h00);
		end
		rq.push_back(24'h0);
		op(8'h0C, 1'b0, 8'h00);
		rq.push_back(24'h0);
		op(CMD_SEL_A, 1'b0, 8'h00);
		op(CMD_MAP_PORT, 1'b1, 8'h80);
		idle(2);
		chk_ptr(7'h00);
		$display("map port test done");
		for (int i = 0; i < 6; i++) begin
			code = 2'((i + 1) % 3);
			@(posedge clk);
			blink_phase <= (i > 2);
			op(CMD_SEL_A, 1'b1, {6'($urandom), code});
			op(CMD_SEL_B, 1'b1, {6'($urandom), code});
			// upper bits were random; only the code may read back
			rq.push_back({22'h0, code});
			op(CMD_SEL_A, 1'b0, 8'h00);
			idle(3);
			exp = code == 2'h1 || (code == 2'h2 && i > 2);
			chk_pins(exp, exp);
		end
		$display("selector test done");
		t1 = 8'($urandom_range(198, 1));
		t2 = 8'($urandom_range(198, 1));
		@(posedge clk);
		shutdown <= 1'b1;
		op(CMD_SEL_A, 1'b1, 8'h03);
		op(CMD_SEL_B, 1'b1, 8'h03);
		op(CMD_ON_TIME, 1'b1, t1);
		idle(4200);
		pq.push_back({12'hFFF, 12'h00A * t1});
		pq.push_back({12'h014, 12'h00A * t1});
		pq.push_back({12'h00A * (12'h18E - t1 - t2), 12'h00A * t2});
		pq.push_back({12'h014, 12'h00A * t2});
		pulse_on = 1'b1;
		@(posedge clk);
		shutdown <= 1'b0;
		repeat (5) @(posedge clk);
		op(CMD_ON_TIME, 1'b1, t2);
		idle(0);
		for (int n = 0; n < 9000 && pq.size() > 0; n++) @(posedge clk);
		shutdown <= 1'b1;
		idle(3);
		chk_pins(1'b0, 1'b0);
		chk(24'h0, 24'(pq.size()));
		chk(24'h0, 24'(rq.size()));
		$display("filament test done");
		wrap_up();
	end
endmodule
`default_nettype wire
